// ---- inc/ssc_pkg.sv ----
// Purpose: Shared constants and types for the synthesizer serial configuration port.
// Assumes: Word layout is data in the upper bits and the register address in the low bits.
// Notes:   Bit positions index the full serial word, address bits included.
`default_nettype none

package ssc_pkg;

  // ==========================================================
  // Word layout
  localparam int WORD_W   = 32;
  localparam int DATA_W   = 29;
  localparam int ADDR_W   = 3;
  localparam int NUM_CFG  = 6;
  localparam int STATUS_W = 25;

  // ==========================================================
  // Addresses
  localparam logic [ADDR_W-1:0] ADDR_CFG0     = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_READBACK = 3'h6;
  localparam int                IDX_CFG2      = 2;
  localparam int                IDX_CFG4      = 4;
  localparam int                IDX_CFG5      = 5;

  // ==========================================================
  // Field positions
  localparam int LOWPWR_BIT      = 5;
  localparam int CP_HIZ_BIT      = 4;
  localparam int OBS_SEL_LSB     = 26;
  localparam int OBS_SEL_MSB     = 28;
  localparam int OBS_SEL_EXT_BIT = 18;
  localparam int RF_A_EN_BIT     = 5;
  localparam int RF_B_EN_BIT     = 8;

  // ==========================================================
  // Observation selector codes
  localparam logic [3:0] OBS_SEL_OFF      = 4'h0;
  localparam logic [3:0] OBS_SEL_LOCK     = 4'h6;
  localparam logic [3:0] OBS_SEL_READBACK = 4'hC;

  // ==========================================================
  // Reset values and readback length
  localparam logic [WORD_W-1:0] WORD_RST  = 32'h0000_0000;
  localparam int                RB_BITS   = 30;
  localparam int                RB_CNT_W  = 5;
  localparam int                SYNC_W    = 2;
  localparam int                PIN_CNT   = 4;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } ssc_word_t;

  typedef enum logic [1:0] {
    RB_IDLE,
    RB_ARMED,
    RB_SHIFT,
    RB_DONE
  } ssc_rb_state_t;

endpackage : ssc_pkg

`default_nettype wire

// ---- logic/ssc_readback_shifter.sv ----
// Purpose: Shifts the read-only word out on falling serial clock edges after a readback command.
// Assumes: Runs on the serial clock; address and snapshot are static while the strobe is high.
// Notes:   Serial clock may stop between frames; nothing here waits on a free-running edge.
`default_nettype none

module ssc_readback_shifter (
  input  wire logic              i_sclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_load_strobe,
  input  wire logic [2:0]        i_addr,
  input  wire ssc_pkg::ssc_word_t i_word,
  output var  logic              o_bit,
  output var  logic              o_busy
);
  import ssc_pkg::*;

  localparam logic [RB_CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [RB_CNT_W-1:0] CNT_LAST = RB_CNT_W'(RB_BITS);

  ssc_rb_state_t         state_r, state_nxt;
  logic [WORD_W-1:0]     sr_r, sr_nxt;
  logic [RB_CNT_W-1:0]   cnt_r, cnt_nxt;
  logic                  bit_r, bit_nxt;

  // ==========================================================
  // Readback sequencing
  always_comb begin
    state_nxt = state_r;
    sr_nxt    = sr_r;
    cnt_nxt   = cnt_r;
    bit_nxt   = bit_r;
    if (!i_load_strobe) begin
      // A new frame cancels any readback in progress
      state_nxt = RB_IDLE;
      bit_nxt   = 1'b0;
    end else begin
      case (state_r)
        RB_IDLE: begin
          // [R12] extra clock arms
          if (i_addr == ADDR_READBACK) begin
            sr_nxt    = i_word;
            state_nxt = RB_ARMED;
          end
        end
        RB_ARMED: begin
          // [R12] MSB on next fall
          bit_nxt   = sr_r[WORD_W-1];
          sr_nxt    = {sr_r[WORD_W-2:0], 1'b0};
          cnt_nxt   = CNT_ONE;
          state_nxt = RB_SHIFT;
        end
        RB_SHIFT: begin
          if (cnt_r == CNT_LAST) begin
            bit_nxt   = 1'b0;
            state_nxt = RB_DONE;
          end else begin
            // [R3] MSB first out
            bit_nxt = sr_r[WORD_W-1];
            sr_nxt  = {sr_r[WORD_W-2:0], 1'b0};
            cnt_nxt = cnt_r + CNT_ONE;
          end
        end
        default: begin
          // Only one readback per strobe-high period
          state_nxt = RB_DONE;
        end
      endcase
    end
  end

  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= RB_IDLE;
      sr_r    <= WORD_RST;
      cnt_r   <= '0;
      bit_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sr_r    <= sr_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
    end
  end

  assign o_bit  = bit_r;
  assign o_busy = (state_r == RB_SHIFT);

endmodule : ssc_readback_shifter

`default_nettype wire

// ---- logic/ssc_top.sv ----
// Purpose: Serial configuration port of a frequency synthesizer: shift, commit, readback, pins.
// Assumes: Host keeps the serial clock still while the load strobe is high, apart from readback.
// Notes:   Shift register lives on the serial clock; register file lives on i_clk.
//
// Function
// [R1] Shift serial data in on rising serial clock while load strobe low.
// [R2] Shift register is 32 bits, one whole register word per transfer.
// [R3] Words go MSB first; upper 29 bits data, lowest three bits address.
// [R4] Load strobe rising edge copies data into the addressed register.
// [R5] Six write-only config registers plus read-only register at address six.
// [R6] Host writes every config register after power-up before relying on it.
// [R7] Host should write registers from address five down to zero.
// [R8] Some settings are double buffered and take effect together.
// [R9] Host sets observation selector to 1100 before a readback.
// [R10] Readback: strobe low, 32 clocks ending in 110, strobe high.
// [R11] First 29 data bits of the readback command may be anything.
// [R12] One clock after strobe rises, then MSB on next fall, 29 more.
// [R13] Host may restore observation selector to 0000 after last bit.
// [R14] Register two bit 5 set places the device in low-power mode.
// [R15] Chip enable low powers down and floats the charge pump.
// [R16] Lock indicator pin high while locked, low while unlocked.
// [R17] RF output gate pin low disables both RF outputs.
// [R18] Register two bits 28:26 select what the observation pin shows.
// [R19] Strobe edge to read-only or unused address changes no config register.
`default_nettype none

module ssc_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_ce,
  input  wire logic                    i_sclk,
  input  wire logic                    i_sdata,
  input  wire logic                    i_load_strobe,
  input  wire logic                    i_chip_enable_pin,
  input  wire logic                    i_rf_output_gate_pin,
  input  wire logic                    i_loop_locked,
  input  wire logic [ssc_pkg::STATUS_W-1:0] i_core_status,
  output var  logic                    o_power_down,
  output var  logic                    o_charge_pump_drive_en,
  output var  logic                    o_rf_out_a_en,
  output var  logic                    o_rf_out_b_en,
  output var  logic                    o_lock_indicator_pin,
  output var  logic                    o_observation_output_pin,
  output var  ssc_pkg::ssc_word_t      o_cfg_words [ssc_pkg::NUM_CFG]
);
  import ssc_pkg::*;

  // ==========================================================
  // Reset release
  logic [SYNC_W-1:0] rst_q_r, rst_q_nxt;
  logic              rst_n;

  always_comb begin
    rst_q_nxt = {rst_q_r[SYNC_W-2:0], 1'b1};
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q_r <= '0;
    end else if (i_ce) begin
      rst_q_r <= rst_q_nxt;
    end
  end

  assign rst_n = rst_q_r[SYNC_W-1];

  // ==========================================================
  // Serial clock domain: input shift register
  logic [WORD_W-1:0] shreg_r, shreg_nxt;

  always_comb begin
    shreg_nxt = shreg_r;
    // [R1] shift while low
    if (!i_load_strobe) begin
      // [R2] 32-bit shift
      shreg_nxt = {shreg_r[WORD_W-2:0], i_sdata};
    end
  end

  always_ff @(posedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r <= WORD_RST;
    end else begin
      shreg_r <= shreg_nxt;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // Order: load strobe, chip enable, RF gate, loop lock
  logic [PIN_CNT-1:0] pin_raw;
  // Strobe idles high; resetting its stages high keeps a false commit out of reset
  localparam logic [PIN_CNT-1:0] PIN_RST = {1'b1, {(PIN_CNT-1){1'b0}}};
  logic [PIN_CNT-1:0] pin_s1_r, pin_s1_nxt;
  logic [PIN_CNT-1:0] pin_s2_r, pin_s2_nxt;
  logic               strobe_d_r, strobe_d_nxt;
  logic               strobe_s, chip_en_s, rf_gate_s, locked_s;

  assign pin_raw   = {i_load_strobe, i_chip_enable_pin, i_rf_output_gate_pin, i_loop_locked};
  assign strobe_s  = pin_s2_r[3];
  assign chip_en_s = pin_s2_r[2];
  assign rf_gate_s = pin_s2_r[1];
  assign locked_s  = pin_s2_r[0];

  always_comb begin
    pin_s1_nxt   = pin_raw;
    pin_s2_nxt   = pin_s1_r;
    strobe_d_nxt = strobe_s;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r   <= PIN_RST;
      pin_s2_r   <= PIN_RST;
      strobe_d_r <= 1'b1;
    end else if (i_ce) begin
      pin_s1_r   <= pin_s1_nxt;
      pin_s2_r   <= pin_s2_nxt;
      strobe_d_r <= strobe_d_nxt;
    end
  end

  logic       commit;
  logic       frame_start;
  ssc_word_t  word_in;

  // [R4] commit on strobe rise
  assign commit      = strobe_s & ~strobe_d_r;
  assign frame_start = ~strobe_s & strobe_d_r;
  // Shift register is static while the strobe is high, so the word crosses quasi-statically
  assign word_in     = shreg_r;

  // ==========================================================
  // Configuration registers
  logic [WORD_W-1:0] cfg_r   [NUM_CFG];
  logic [WORD_W-1:0] cfg_nxt [NUM_CFG];
  logic [WORD_W-1:0] cfg4_act_r, cfg4_act_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : g_cfg
      always_comb begin
        cfg_nxt[g] = cfg_r[g];
        // [R5] six writable words
        // [R19] other addresses ignored
        if (commit && (word_in.addr == ADDR_W'(g))) begin
          // [R3] data and address
          cfg_nxt[g] = word_in;
        end
      end

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_r[g] <= WORD_RST;
        end else if (i_ce) begin
          cfg_r[g] <= cfg_nxt[g];
        end
      end

      if (g == IDX_CFG4) begin : g_dbuf
        assign o_cfg_words[g] = cfg4_act_r;
      end else begin : g_direct
        assign o_cfg_words[g] = cfg_r[g];
      end
    end
  endgenerate

  always_comb begin
    cfg4_act_nxt = cfg4_act_r;
    // [R8] staged until word zero
    if (commit && (word_in.addr == ADDR_CFG0)) begin
      cfg4_act_nxt = cfg_nxt[IDX_CFG4];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg4_act_r <= WORD_RST;
    end else if (i_ce) begin
      cfg4_act_r <= cfg4_act_nxt;
    end
  end

  // ==========================================================
  // Pin-level control outputs
  logic       pwr_down_r, pwr_down_nxt;
  logic       cp_drive_r, cp_drive_nxt;
  logic       rf_a_r, rf_a_nxt;
  logic       rf_b_r, rf_b_nxt;
  logic       lock_r, lock_nxt;
  logic       obs_r, obs_nxt;
  logic       sel_rb_r, sel_rb_nxt;
  logic [3:0] obs_sel;

  // [R18] selector field
  assign obs_sel = {cfg_r[IDX_CFG5][OBS_SEL_EXT_BIT],
                    cfg_r[IDX_CFG2][OBS_SEL_MSB:OBS_SEL_LSB]};

  always_comb begin
    // [R14] low-power bit
    // [R15] chip enable low
    pwr_down_nxt = ~chip_en_s | cfg_r[IDX_CFG2][LOWPWR_BIT];
    cp_drive_nxt = ~pwr_down_nxt & ~cfg_r[IDX_CFG2][CP_HIZ_BIT];
    // [R17] gate overrides enables
    rf_a_nxt     = rf_gate_s & cfg4_act_r[RF_A_EN_BIT] & ~pwr_down_nxt;
    rf_b_nxt     = rf_gate_s & cfg4_act_r[RF_B_EN_BIT] & ~pwr_down_nxt;
    // [R16] lock follows loop
    lock_nxt     = locked_s;
    obs_nxt      = 1'b0;
    if (obs_sel == OBS_SEL_LOCK) begin
      obs_nxt = locked_s;
    end
    // Off and unlisted codes hold the pin low
    sel_rb_nxt   = (obs_sel == OBS_SEL_READBACK);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_down_r <= 1'b1;
      cp_drive_r <= 1'b0;
      rf_a_r     <= 1'b0;
      rf_b_r     <= 1'b0;
      lock_r     <= 1'b0;
      obs_r      <= 1'b0;
      sel_rb_r   <= 1'b0;
    end else if (i_ce) begin
      pwr_down_r <= pwr_down_nxt;
      cp_drive_r <= cp_drive_nxt;
      rf_a_r     <= rf_a_nxt;
      rf_b_r     <= rf_b_nxt;
      lock_r     <= lock_nxt;
      obs_r      <= obs_nxt;
      sel_rb_r   <= sel_rb_nxt;
    end
  end

  // ==========================================================
  // Read-only word snapshot
  // Taken at frame start, so it is long settled before the serial side reads it
  ssc_word_t snap_r, snap_nxt;

  always_comb begin
    snap_nxt = snap_r;
    if (frame_start) begin
      snap_nxt = {i_core_status, lock_r, pwr_down_r, rf_a_r, rf_b_r, ADDR_READBACK};
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= WORD_RST;
    end else if (i_ce) begin
      snap_r <= snap_nxt;
    end
  end

  // ==========================================================
  // Readback path
  logic rb_bit;

  // [R12] falling-edge readback
  ssc_readback_shifter u_rb (
    .i_sclk        (i_sclk),
    .i_rst_n       (rst_n),
    .i_load_strobe (i_load_strobe),
    .i_addr        (shreg_r[ADDR_W-1:0]),
    .i_word        (snap_r),
    .o_bit         (rb_bit),
    .o_busy        ()
  );

  // ==========================================================
  // Outputs
  assign o_power_down           = pwr_down_r;
  assign o_charge_pump_drive_en = cp_drive_r;
  assign o_rf_out_a_en          = rf_a_r;
  assign o_rf_out_b_en          = rf_b_r;
  assign o_lock_indicator_pin   = lock_r;
  // Readback bits come straight from the serial-clock flop; a resample on i_clk would lag
  assign o_observation_output_pin = sel_rb_r ? rb_bit : obs_r;

endmodule : ssc_top

`default_nettype wire

// ---- verification/ssc_host.sv ----
// Purpose: Behavioural host on the serial configuration link.
// Assumes: Serial clock period 80 ns, held low between frames.
// Notes:   A released data line shows the inverse of its last bit.
`default_nettype none

module ssc_host (
  output var  logic o_sclk,
  output var  logic o_sdata,
  output var  logic o_load_strobe,
  input  wire logic i_obs
);
  timeunit 1ns / 1ps;

  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_load_strobe = 1'b1;
  end

  // =========
  // Frames
  // MSB first, 32 clocks
  task automatic send(input logic [31:0] w);
    o_load_strobe = 1'b0;
    #120;
    for (int i = 31; i >= 0; i--) begin
      o_sdata = w[i];
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
    o_sdata = ~w[0];
    #20 o_load_strobe = 1'b1;
    // Long gap so the commit lands before the next frame
    #600;
  endtask : send

  task automatic rd_back(output logic [31:0] r);
    r = 32'h0;
    send(32'hFFFF_FFFE);
    o_sclk = 1'b1;
    #40 o_sclk = 1'b0;
    #40;
    for (int i = 31; i >= 2; i--) begin
      o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
      #30 r[i] = i_obs;
      #10;
    end
  endtask : rd_back

endmodule : ssc_host

`default_nettype wire

// ---- verification/ssc_top_asserts.sv ----
// Purpose: Pin-level assertions for the serial configuration port.
// Assumes: Reset is applied once; no watched pin rises while i_ce is low.
// Notes:   A shadow shift register recovers the address of each frame.
`default_nettype none

module ssc_top_asserts (
  input wire logic               i_clk,
  input wire logic               i_rstn,
  input wire logic               i_sclk,
  input wire logic               i_sdata,
  input wire logic               i_load_strobe,
  input wire logic               i_chip_enable_pin,
  input wire logic               i_rf_output_gate_pin,
  input wire logic               i_loop_locked,
  input wire logic               o_power_down,
  input wire logic               o_charge_pump_drive_en,
  input wire logic               o_rf_out_a_en,
  input wire logic               o_rf_out_b_en,
  input wire logic               o_lock_indicator_pin,
  input wire logic               o_observation_output_pin,
  input wire ssc_pkg::ssc_word_t o_cfg_words [ssc_pkg::NUM_CFG]
);
  timeunit 1ns / 1ps;
  import ssc_pkg::*;

  logic [31:0]  sh_r;
  logic [191:0] all_w;
  logic [3:0]   sel;

  // =========
  // Frame shadow
  always_ff @(posedge i_sclk) begin
    if (!i_load_strobe) begin
      sh_r <= {sh_r[30:0], i_sdata};
    end
  end
  assign all_w = {o_cfg_words[0], o_cfg_words[1], o_cfg_words[2],
                  o_cfg_words[3], o_cfg_words[4], o_cfg_words[5]};
  assign sel = {o_cfg_words[5][OBS_SEL_EXT_BIT], o_cfg_words[2][OBS_SEL_MSB:OBS_SEL_LSB]};

  // =========
  // Properties
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_commit;
    $rose(i_load_strobe) && sh_r[2:0] < 3'h6 && sh_r[2:0] != 3'h4
      |-> ##[3:5] o_cfg_words[sh_r[2:0]].data == sh_r[31:3];
  endproperty
  a_commit: assert property (p_commit) else $error("word not committed");
  property p_refuse;
    $rose(i_load_strobe) && sh_r[2:0] >= 3'h6 |-> $stable(all_w) [*6];
  endproperty
  a_refuse: assert property (p_refuse) else $error("config changed");
  property p_dbuf;
    $rose(i_load_strobe) && sh_r[2:0] == 3'h4 |-> $stable(o_cfg_words[4]) [*6];
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("staged word applied");
  property p_lowpwr;
    o_cfg_words[2][LOWPWR_BIT] && $past(o_cfg_words[2][LOWPWR_BIT]) |-> o_power_down;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("no low power");
  property p_ce_off;
    (!i_chip_enable_pin) [*4] |-> o_power_down && !o_charge_pump_drive_en;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("still powered");
  property p_lock; i_loop_locked [*4] |-> o_lock_indicator_pin; endproperty
  a_lock: assert property (p_lock) else $error("lock pin low");
  property p_gate;
    (!i_rf_output_gate_pin) [*4] |-> !o_rf_out_a_en && !o_rf_out_b_en;
  endproperty
  a_gate: assert property (p_gate) else $error("rf output on");
  property p_obs_off; (sel == 4'h0) [*2] |-> !o_observation_output_pin; endproperty
  a_obs_off: assert property (p_obs_off) else $error("obs pin high");

  c_rdbk: cover property ($rose(i_load_strobe) && sh_r[2:0] == 3'h6);
  c_pd: cover property ($rose(o_power_down));
  c_gate: cover property ($fell(o_rf_out_a_en));

endmodule : ssc_top_asserts

bind ssc_top ssc_top_asserts u_chk (
  .i_clk, .i_rstn, .i_sclk, .i_sdata, .i_load_strobe, .i_chip_enable_pin,
  .i_rf_output_gate_pin, .i_loop_locked, .o_power_down, .o_charge_pump_drive_en,
  .o_rf_out_a_en, .o_rf_out_b_en, .o_lock_indicator_pin, .o_observation_output_pin,
  .o_cfg_words
);

`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the serial configuration port.
// Assumes: The host model makes the serial clock; i_ce high apart from one freeze check.
// Notes:   Expected words tracked here, staging of word four included.
`default_nettype none

module tb_top;
  timeunit 1ns / 1ps;
  import ssc_pkg::*;

  localparam logic [31:0] V2 = 32'h0123_4C02;
  localparam logic [31:0] V4 = 32'h0ACE_0124;
  localparam logic [31:0] V5 = 32'h0000_0005;

  logic                clk = 1'b0;
  logic                rstn = 1'b0;
  logic                cep = 1'b1;
  logic                ce = 1'b1;
  logic                gate = 1'b1;
  logic                lock = 1'b0;
  logic [STATUS_W-1:0] st = 25'h1AB_CDEF;
  wire logic           sclk;
  wire logic           sd;
  wire logic           ls;
  logic                pd, cp, ra, rb, ld, obs;
  ssc_word_t           cw [NUM_CFG];
  logic [31:0]         act [NUM_CFG] = '{default: 32'h0};
  logic [31:0]         stg = 32'h0;
  int                  n_fail = 0;
  int                  n_tests = 0;

  always #50 clk = ~clk;

  ssc_top dut (
    .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_sclk(sclk), .i_sdata(sd),
    .i_load_strobe(ls), .i_chip_enable_pin(cep), .i_rf_output_gate_pin(gate),
    .i_loop_locked(lock), .i_core_status(st), .o_power_down(pd),
    .o_charge_pump_drive_en(cp), .o_rf_out_a_en(ra), .o_rf_out_b_en(rb),
    .o_lock_indicator_pin(ld), .o_observation_output_pin(obs), .o_cfg_words(cw)
  );
  ssc_host host (.o_sclk(sclk), .o_sdata(sd), .o_load_strobe(ls), .i_obs(obs));

  // =========
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Word four is staged and only goes live with a commit to address zero
  task automatic wr(input logic [31:0] w);
    host.send(w);
    if (w[2:0] == 3'h4) begin
      stg = w;
    end else if (w[2:0] < 3'h6) begin
      act[w[2:0]] = w;
    end
    if (w[2:0] == 3'h0) begin
      act[4] = stg;
    end
    repeat (3) @(negedge clk);
    for (int i = 0; i < NUM_CFG; i++) begin
      chk("cfg", {3'h0, act[i][31:3]}, {3'h0, cw[i].data});
    end
  endtask : wr

  // =========
  // Scenarios
  task automatic t_write();
    wr(V5);
    wr(V4);
    wr(32'h1357_9BD3);
    wr(V2);
    wr(32'h8765_4321);
    wr(32'hDEAD_BEE8);
    chk("rf_a", 1'b1, ra);
    chk("rf_b", 1'b1, rb);
  endtask : t_write

  task automatic t_refuse();
    wr(32'h2468_ACEE);
    wr(32'hFFFF_FFFF);
  endtask : t_refuse

  task automatic t_pins();
    wr(V2 | 32'h20);
    chk("pd", 1'b1, pd);
    wr(V2);
    chk("pd", 1'b0, pd);
    cep = 1'b0;
    repeat (5) @(negedge clk);
    chk("pd", 1'b1, pd);
    chk("cp", 1'b0, cp);
    cep = 1'b1;
    gate = 1'b0;
    lock = 1'b1;
    repeat (5) @(negedge clk);
    chk("cp", 1'b1, cp);
    chk("rf_a", 1'b0, ra);
    chk("rf_b", 1'b0, rb);
    chk("lock", 1'b1, ld);
    gate = 1'b1;
    // Clock enable low must freeze the pin path
    ce   = 1'b0;
    lock = 1'b0;
    repeat (5) @(negedge clk);
    chk("lock_frozen", 1'b1, ld);
    ce = 1'b1;
    repeat (5) @(negedge clk);
    chk("lock", 1'b0, ld);
    lock = 1'b1;
  endtask : t_pins

  task automatic t_read();
    logic [31:0] r;
    wr(V5 | 32'h0004_0000);
    wr(V2 | 32'h1000_0000);
    host.rd_back(r);
    chk("rdbk", {2'h0, st, 5'h17}, {2'h0, r[31:2]});
    wr(V2);
    wr(V5);
    chk("obs", 1'b0, obs);
    wr(V2 | 32'h1800_0000);
    chk("obs", 1'b1, obs);
    lock = 1'b0;
    repeat (5) @(negedge clk);
    chk("lock", 1'b0, ld);
    chk("obs", 1'b0, obs);
  endtask : t_read

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_write();
    t_refuse();
    t_pins();
    t_read();
    end_sim();
  end

  // Some sixteen frames of about 4 us each fit well inside this
  initial begin
    #400_000;
    n_fail++;
    end_sim();
  end

endmodule : tb_top

`default_nettype wire
